// >>> include/iss_pkg.sv
// constants shared by the serial port slave engine
package iss_pkg;
  // mode field encodings
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_SLV10 = 4'h7;
  localparam logic [3:0] MODE_MST = 4'h8;
  localparam logic [3:0] MODE_FWMST = 4'hb;
  localparam logic [3:0] MODE_SLV7_SP = 4'he;
  localparam logic [3:0] MODE_SLV10_SP = 4'hf;
  // ten-bit header pattern in the top five bits of the first byte
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
  // bit counts within a byte frame
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;
  // data width and fifo depth
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
endpackage

// >>> design/iss_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
module iss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("fifo depth must be a power of two of at least two");
    end
  end

  // handshake terms
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> design/iss_slave.sv
// serial port slave engine with address match and clock stretching
// Function
// - whole port stays idle until port_enable is set
// - four bit mode field picks one of six modes
// - pins driven only open drain when direction bits select input
// - address match always flags; start/stop flag only in those modes
// - matched address or data byte is acknowledged and buffered
// - full or overflow beforehand: no ack, buffer kept, flag still set
// - buffer read clears full; overflow cleared only by software
// - wait for start, shift eight bits on rising scl
// - compare shift bits seven to one with own address after bit eight
// - on match load buffer, set full, ack, flag at ninth fall
// - ten bit header is 11110, two msbs, write bit, then low byte
// - ten bit write header and low address byte set update_address until address written
// - write direction clears read flag, buffers address, acks
// - flag once per byte, held until software clears it
// - read direction sets read flag, acks, stretches scl always
// - transmit write loads shift reg, shifted out on falling scl
// - master nack on ninth rise resets status, waits for start
// - stretch enable holds scl after a received data byte while the buffer is still full
// - data receive in seven or ten bit mode with stretch enable clears clock_release at ninth fall if full
// - software may set clock_release whatever the full state
// - ten bit address phase stretches while update_address is set
// - full based stretching only in data phases
`timescale 1ns/1ns
module iss_slave #(
  parameter int FIFO_W = iss_pkg::DATA_W,
  parameter int FIFO_D = iss_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic port_enable,
  input wire logic [3:0] mode_sel,
  input wire logic stretch_enable,
  input wire logic [1:0] pin_direction_bits,
  input wire logic [9:0] own_address_reg,
  input wire logic addr_write,
  input wire logic buf_read,
  input wire logic irq_clear,
  input wire logic overflow_clear,
  input wire logic clock_release_set,
  input wire logic [7:0] tx_data,
  input wire logic tx_write,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] rx_tx_buffer,
  output logic buffer_full,
  output logic receive_overflow,
  output logic port_irq_flag,
  output logic update_address,
  output logic read_write,
  output logic clock_release,
  output logic start_seen,
  output logic stop_seen,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data
);
  typedef enum logic [4:0] {
    ISS_IDLE = 5'h01,
    ISS_ADDR = 5'h02,
    ISS_RX = 5'h04,
    ISS_TX = 5'h08,
    ISS_ACKIN = 5'h10
  } iss_state_t;

  initial begin
    if (FIFO_W != iss_pkg::DATA_W) begin
      $error("fifo width must match the byte width");
    end
  end

  iss_state_t st_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [7:0] shift_reg_q;
  logic [3:0] bit_cnt_q;
  logic ack_q;
  logic hold_q;
  logic ten_hi_q;
  logic ten_done_q;
  logic data_phase_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_push;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic slave_mode;
  logic ten_mode;
  logic sp_mode;
  logic active;
  logic pins_ok;
  logic addr_hit;
  logic byte_done;
  logic ninth_fall;
  logic accept;
  logic ten_low;

  // two flip-flop synchronisers for the pins
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // mode decode and bus events
  assign ten_mode = (mode_sel == iss_pkg::MODE_SLV10)
    || (mode_sel == iss_pkg::MODE_SLV10_SP);
  assign sp_mode = (mode_sel == iss_pkg::MODE_SLV7_SP)
    || (mode_sel == iss_pkg::MODE_SLV10_SP);
  assign slave_mode = ten_mode || sp_mode
    || (mode_sel == iss_pkg::MODE_SLV7);
  assign active = port_enable && slave_mode;
  assign pins_ok = &pin_direction_bits;
  assign scl_rise = scl_sync_q[1] && !scl_prev_q;
  assign scl_fall = !scl_sync_q[1] && scl_prev_q;
  assign start_det = scl_sync_q[1] && scl_prev_q
    && sda_prev_q && !sda_sync_q[1];
  assign stop_det = scl_sync_q[1] && scl_prev_q
    && !sda_prev_q && sda_sync_q[1];
  assign byte_done = scl_fall && (bit_cnt_q == iss_pkg::BITS_PER_BYTE);
  assign ninth_fall = scl_fall && (bit_cnt_q == iss_pkg::ACK_BIT);
  assign accept = !buffer_full && !receive_overflow;
  // the low address byte follows a matched header whose lsb is 0 (write)
  assign ten_low = ten_mode && ten_hi_q && !ten_done_q;

  // address compare for seven bit, ten bit high and ten bit low bytes
  always_comb begin
    addr_hit = 1'b0;
    if (!ten_mode) begin
      addr_hit = shift_reg_q[7:1] == own_address_reg[6:0];
    end else if (ten_low) begin
      addr_hit = shift_reg_q == own_address_reg[7:0];
    end else begin
      addr_hit = (shift_reg_q[7:3] == iss_pkg::TEN_BIT_HDR)
        && (shift_reg_q[2:1] == own_address_reg[9:8]);
      if (shift_reg_q[0] && !ten_done_q) begin
        addr_hit = 1'b0; // read needs a completed write address first
      end
    end
  end

  // bit counter, shift register and transfer state
  always_ff @(posedge clk) begin
    if (reset || !active) begin
      st_q <= ISS_IDLE;
      bit_cnt_q <= '0;
      shift_reg_q <= '0;
      ack_q <= 1'b0;
      ten_hi_q <= 1'b0;
      ten_done_q <= 1'b0;
      data_phase_q <= 1'b0;
    end else if (start_det) begin
      st_q <= ISS_ADDR;
      bit_cnt_q <= '0;
      ack_q <= 1'b0;
      data_phase_q <= 1'b0;
      if (!ten_done_q) begin
        ten_hi_q <= 1'b0;
      end
    end else if (stop_det) begin
      st_q <= ISS_IDLE;
      ten_hi_q <= 1'b0;
      ten_done_q <= 1'b0;
    end else begin
      if (tx_write && st_q == ISS_TX) begin
        shift_reg_q <= tx_data;
      end
      if (scl_rise && st_q != ISS_IDLE) begin
        bit_cnt_q <= bit_cnt_q + 4'h1; // the start's own fall is not a bit
        if (bit_cnt_q < iss_pkg::BITS_PER_BYTE && st_q != ISS_TX) begin
          shift_reg_q <= {shift_reg_q[6:0], sda_sync_q[1]};
        end
        if (st_q == ISS_ACKIN && sda_sync_q[1]) begin
          st_q <= ISS_IDLE;
        end
      end
      if (scl_fall && st_q == ISS_TX
          && bit_cnt_q < iss_pkg::BITS_PER_BYTE) begin
        shift_reg_q <= {shift_reg_q[6:0], 1'b0};
      end
      if (byte_done) begin
        if (st_q == ISS_ADDR) begin
          ack_q <= addr_hit && accept;
          if (!addr_hit) begin
            st_q <= ISS_IDLE;
          end else if (ten_low) begin
            ten_done_q <= 1'b1;
          end else if (ten_mode && !shift_reg_q[0]) begin
            ten_hi_q <= 1'b1;
            ten_done_q <= 1'b0;
          end
        end else if (st_q == ISS_RX) begin
          ack_q <= accept;
        end else if (st_q == ISS_TX) begin
          st_q <= ISS_ACKIN;
        end
      end
      if (ninth_fall) begin
        bit_cnt_q <= '0;
        ack_q <= 1'b0;
        if (st_q == ISS_ADDR) begin
          if (read_write) begin
            st_q <= ISS_TX;
            data_phase_q <= 1'b1;
          end else if (!ten_mode || ten_done_q) begin
            st_q <= ISS_RX;
            data_phase_q <= 1'b1;
          end
        end else if (st_q == ISS_ACKIN) begin
          st_q <= ISS_TX;
        end
      end
    end
  end

  // buffer, full, overflow and direction status
  always_ff @(posedge clk) begin
    if (reset || !active) begin
      rx_tx_buffer <= '0;
      buffer_full <= 1'b0;
      receive_overflow <= 1'b0;
      read_write <= 1'b0;
    end else begin
      if (buf_read) begin
        buffer_full <= 1'b0;
      end
      if (overflow_clear) begin
        receive_overflow <= 1'b0;
      end
      if (tx_write && st_q == ISS_TX) begin
        rx_tx_buffer <= tx_data;
        buffer_full <= 1'b1;
      end
      if (byte_done
          && (st_q == ISS_RX || (st_q == ISS_ADDR && addr_hit))) begin
        if (accept) begin
          rx_tx_buffer <= shift_reg_q;
          buffer_full <= 1'b1;
        end else if (st_q == ISS_RX) begin
          receive_overflow <= 1'b1;
        end
        if (st_q == ISS_ADDR && !ten_low) begin
          read_write <= shift_reg_q[0];
        end
      end
      if (byte_done && st_q == ISS_TX) begin
        buffer_full <= 1'b0;
      end
      if (scl_rise && st_q == ISS_ACKIN && sda_sync_q[1]) begin
        read_write <= 1'b0;
      end
    end
  end

  // interrupt flag and start/stop status
  always_ff @(posedge clk) begin
    if (reset || !active) begin
      port_irq_flag <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      if (start_det) begin
        start_seen <= 1'b1;
        stop_seen <= 1'b0;
      end
      if (stop_det) begin
        stop_seen <= 1'b1;
        start_seen <= 1'b0;
      end
      if (ninth_fall && st_q != ISS_IDLE) begin
        port_irq_flag <= 1'b1;
      end else if (sp_mode && (start_det || stop_det)) begin
        port_irq_flag <= 1'b1;
      end else if (irq_clear) begin
        port_irq_flag <= 1'b0;
      end
    end
  end

  // update_address flag for ten bit addressing
  always_ff @(posedge clk) begin
    if (reset || !active) begin
      update_address <= 1'b0;
    end else if (byte_done && st_q == ISS_ADDR && addr_hit && ten_mode
        && (ten_low || !shift_reg_q[0])) begin
      update_address <= 1'b1;
    end else if (addr_write) begin
      update_address <= 1'b0;
    end
  end

  // clock_release bit and the stretch hold
  always_ff @(posedge clk) begin
    if (reset || !active) begin
      clock_release <= 1'b1;
      hold_q <= 1'b0;
    end else begin
      if (clock_release_set) begin
        clock_release <= 1'b1;
      end
      if (ninth_fall && st_q == ISS_ADDR && read_write) begin
        clock_release <= 1'b0;
      end else if (ninth_fall && st_q == ISS_ACKIN && !buffer_full) begin
        clock_release <= 1'b0;
      end else if (ninth_fall && st_q == ISS_RX && data_phase_q
          && stretch_enable && buffer_full) begin
        clock_release <= 1'b0;
      end
      if (ninth_fall && st_q == ISS_ADDR && ten_mode && update_address) begin
        hold_q <= 1'b1;
      end else if (addr_write) begin
        hold_q <= 1'b0;
      end
    end
  end

  // open drain pin drive, low only when enabled
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= active && pins_ok && !scl_sync_q[1]
        && (!clock_release || hold_q);
      sda_oe <= active && pins_ok && (ack_q
        || (st_q == ISS_TX && bit_cnt_q <= iss_pkg::BITS_PER_BYTE
        && !shift_reg_q[7]));
    end
  end

  // received data bytes also stream into the fifo
  assign fifo_push = byte_done && st_q == ISS_RX && accept;

  iss_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(shift_reg_q),
    .out_valid(fifo_out_valid),
    .out_ready(rx_ready && !rx_valid),
    .out_data(fifo_out_data)
  );

  // registered fifo output stage
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
    end else if (fifo_out_valid && rx_ready && !rx_valid) begin
      rx_valid <= 1'b1;
      rx_data <= fifo_out_data;
    end else begin
      rx_valid <= 1'b0;
    end
  end
endmodule

// >>> dv/iss_slave_chk.sv
// port assertions for the serial port slave engine
`timescale 1ns/1ns
module iss_slave_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic port_enable,
  input wire logic [1:0] pin_direction_bits,
  input wire logic addr_write,
  input wire logic buf_read,
  input wire logic irq_clear,
  input wire logic overflow_clear,
  input wire logic clock_release_set,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic buffer_full,
  input wire logic receive_overflow,
  input wire logic port_irq_flag,
  input wire logic update_address,
  input wire logic read_write,
  input wire logic clock_release
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // pins, sticky flags and clock hold against their causes
  a_idle_quiet: assert property ((!port_enable) [*2] |->
    !scl_oe && !sda_oe) else $error("pin driven while disabled");
  a_dir_gate: assert property ((pin_direction_bits != 2'h3) [*2] |->
    !scl_oe && !sda_oe) else $error("pin driven while not input");
  a_open_drain: assert property (scl_out == 1'b0 &&
    sda_out == 1'b0) else $error("pin driven high");
  a_ovf_cause: assert property ($rose(receive_overflow) |->
    $past(buffer_full)) else $error("overflow without full buffer");
  a_ovf_noack: assert property (receive_overflow |->
    !sda_oe) else $error("ack given during overflow");
  a_ovf_sticky: assert property (receive_overflow && port_enable &&
    !overflow_clear |=> receive_overflow) else $error("overflow lost");
  a_full_clear: assert property (buf_read && port_enable |=>
    !buffer_full) else $error("full kept after read");
  a_flag_sticky: assert property (port_irq_flag && port_enable &&
    !irq_clear |=> port_irq_flag) else $error("flag lost");
  a_ua_clear: assert property (addr_write && port_enable |=>
    !update_address) else $error("update flag kept");
  a_ckp_set: assert property (clock_release_set && port_enable |=>
    clock_release) else $error("clock release not set");
  a_hold_cause: assert property ((scl_oe && clock_release &&
    !update_address && !read_write) [*3] |=> !scl_oe)
    else $error("clock held without cause");
  // main scenarios reached
  c_flag: cover property ($rose(port_irq_flag));
  c_ovf: cover property ($rose(receive_overflow));
  c_ua: cover property ($rose(update_address));
  c_read: cover property (read_write && scl_oe);
endmodule
bind iss_slave iss_slave_chk chk_u (.*);

// >>> dv/iss_i2c_master.sv
// bus master model: open drain clock and data with pull-ups
`timescale 1ns/1ns
module iss_i2c_master (
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  int low_extra = 0;
  // a released line is pulled high
  assign scl = !(scl_oe || scl_low);
  assign sda = !(sda_oe || sda_low);
  // release the clock and wait out any stretch, bounded
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 5000) begin
      #40;
      n++;
    end
    #80;
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    #80;
    rise();
    #80;
    sda_low = 1'b1;
    #160;
    scl_low = 1'b1;
    #80;
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    #80;
    rise();
    #80;
    sda_low = 1'b0;
    #160;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic mack,
      output logic [7:0] got, output logic acked);
    for (int i = 8; i >= 0; i--) begin
      #40;
      sda_low = (i > 0) ? !d[i-1] : mack;
      #(120 + low_extra);
      rise();
      if (i > 0) got = {got[6:0], sda};
      else acked = !sda;
      #80;
      scl_low = 1'b1;
    end
  endtask
endmodule

// >>> dv/test_i2c_slave_addr_stretch.sv
// self-checking bench for the serial port slave engine
`timescale 1ns/1ns
module test_i2c_slave_addr_stretch;
  typedef struct packed {
    logic en;
    logic [3:0] mode;
    logic [7:0] byt;
    logic [2:0] exp;
  } iss_row_t;
  logic clk, reset, port_enable, stretch_enable, addr_write, buf_read;
  logic irq_clear, overflow_clear, clock_release_set, tx_write, rx_ready;
  logic scl_in, sda_in, scl_out, sda_out, scl_oe, sda_oe, start_seen;
  logic stop_seen, buffer_full, receive_overflow, port_irq_flag, ack;
  logic update_address, read_write, clock_release, rx_valid;
  logic [3:0] mode_sel;
  logic [1:0] pin_direction_bits;
  logic [9:0] own_address_reg;
  logic [7:0] tx_data, rx_tx_buffer, rx_data, got;
  logic [7:0] rxq[$];
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  // enable, mode, address byte, expected ack, flag, read direction
  iss_row_t rows[9] = '{
    {1'b0, iss_pkg::MODE_SLV7, 8'h54, 3'h0},
    {1'b1, iss_pkg::MODE_SLV7, 8'h54, 3'h6},
    {1'b1, iss_pkg::MODE_SLV7, 8'h56, 3'h0},
    {1'b1, iss_pkg::MODE_SLV7_SP, 8'h56, 3'h2},
    {1'b1, iss_pkg::MODE_SLV7_SP, 8'h55, 3'h7},
    {1'b1, iss_pkg::MODE_MST, 8'h54, 3'h0},
    {1'b1, iss_pkg::MODE_FWMST, 8'h54, 3'h0},
    {1'b1, iss_pkg::MODE_SLV10, 8'h54, 3'h0},
    {1'b1, iss_pkg::MODE_SLV10_SP, 8'h56, 3'h2}};
  iss_slave dut_u (.*);
  iss_i2c_master m_u (.scl(scl_in), .sda(sda_in), .scl_oe(scl_oe),
    .sda_oe(sda_oe));
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cycle limit and capture of bytes leaving the fifo
  always @(negedge clk) begin
    cycles++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
    if (cycles == 60000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [7:0] e,
      input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  // one-cycle software strobes
  task automatic pulse(input logic [5:0] p);
    @(negedge clk);
    {tx_write, clock_release_set, overflow_clear, irq_clear, buf_read,
      addr_write} = p;
    @(negedge clk);
    {tx_write, clock_release_set, overflow_clear, irq_clear, buf_read,
      addr_write} = 6'h00;
  endtask
  task automatic send(input logic [7:0] d);
    m_u.xfer(d, 1'b0, got, ack);
    #400;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    reset = 1'b1;
    {port_enable, stretch_enable, rx_ready} = 3'h0;
    pulse_init: {tx_write, clock_release_set, overflow_clear, irq_clear,
      buf_read, addr_write} = 6'h00;
    mode_sel = iss_pkg::MODE_SLV7;
    pin_direction_bits = 2'h0;
    own_address_reg = 10'h02a;
    tx_data = 8'h9c;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    pin_direction_bits = 2'h3;
    @(negedge clk);
    chk("scl_oe", 8'h0, scl_oe);
    chk("clock_release", 8'h1, clock_release);
    foreach (rows[i]) begin
      port_enable = rows[i].en;
      mode_sel = rows[i].mode;
      m_u.start();
      send(rows[i].byt);
      chk("ack", rows[i].exp[2], ack);
      chk("flag", rows[i].exp[1], port_irq_flag);
      chk("read_write", rows[i].exp[0], read_write);
      if (rows[i].exp[2]) chk("buffer", rows[i].byt, rx_tx_buffer);
      if (rows[i].exp[0]) begin
        chk("read hold", 8'h1, scl_oe);
        pulse(6'h06);
        pulse(6'h20);
        pulse(6'h10);
        m_u.xfer(8'hff, 1'b0, got, ack);
        chk("tx byte", 8'h9c, got);
        #400;
        chk("nack reset", 8'h0, read_write);
      end
      m_u.stop();
      pulse(6'h0e);
      $display("row %0d done", i);
    end
    stretch_enable = 1'b1;
    mode_sel = iss_pkg::MODE_SLV7;
    m_u.start();
    send(8'h54);
    chk("addr hold", 8'h0, scl_oe);
    send(8'h3c);
    chk("ack", 8'h0, ack);
    chk("buffer", 8'h54, rx_tx_buffer);
    chk("overflow", 8'h1, receive_overflow);
    chk("flag", 8'h1, port_irq_flag);
    chk("clock_release", 8'h0, clock_release);
    pulse(6'h02);
    chk("full", 8'h0, buffer_full);
    chk("overflow", 8'h1, receive_overflow);
    pulse(6'h1c);
    chk("overflow", 8'h0, receive_overflow);
    m_u.stop();
    $display("overflow test done");
    m_u.low_extra = 400;
    m_u.start();
    send(8'h54);
    pulse(6'h06);
    for (int k = 0; k < 9; k++) begin
      if (k == 1) fork
        send(8'h11);
        begin
          wait (buffer_full === 1'b1);
          pulse(6'h02);
        end
      join
      else send(8'h10 + 8'(k));
      if (k < 8) chk("data ack", 8'h1, ack);
      if (k < 2) chk("data hold", 8'(k == 0), scl_oe);
      if (k == 0) chk("data", 8'h10, rx_tx_buffer);
      pulse(6'h16);
    end
    m_u.stop();
    m_u.low_extra = 0;
    rx_ready = 1'b1;
    repeat (30) @(negedge clk);
    chk("fifo count", 8'h1, 8'(rxq.size() >= 8));
    for (int j = 0; j < 8 && j < rxq.size(); j++)
      chk("fifo data", 8'h10 + 8'(j), rxq[j]);
    $display("stretch and fifo test done");
    own_address_reg = 10'h2a5;
    mode_sel = iss_pkg::MODE_SLV10;
    m_u.start();
    send(8'hf4);
    chk("header ack", 8'h1, ack);
    chk("start_seen", 8'h1, start_seen);
    chk("update", 8'h1, update_address);
    chk("ua hold", 8'h1, scl_oe);
    chk("clock_release", 8'h1, clock_release);
    pulse(6'h07);
    chk("update", 8'h0, update_address);
    send(8'ha5);
    chk("low ack", 8'h1, ack);
    chk("update", 8'h1, update_address);
    pulse(6'h07);
    send(8'h77);
    chk("data ack", 8'h1, ack);
    chk("update", 8'h0, update_address);
    pulse(6'h16);
    m_u.stop();
    chk("stop_seen", 8'h1, stop_seen);
    chk("start_seen", 8'h0, start_seen);
    $display("ten bit test done");
    final_report();
  end
endmodule
